// *** hw/fmos_top.sv ***
// Operator-slot register arrays, slot and channel mapping and envelope sequencing.
`include "fmos_defs.svh"
// Functional notes
// - Two select bits pick four-operator algorithm
// - Unused channel bits stored, no sound effect
// - Legacy mode: mono, both outputs enabled
// - Per-slot three-bit waveform field
// - Legacy mode honours waveforms zero to three
// - Envelope spans 96 dB in 0.1875 dB
// - Key on: exponential attack, linear decay
// - Sustained envelope holds while key stays on
// - Key off releases sustained envelope
// - Percussive envelope releases after sustain level
// - Rates below four frozen; fixed time scale
// - Thirty-six slots, per-slot or per-channel parameters
// - Slot index nibbles 6,7,E,F unmapped
// - Slots split over arrays, grouped offsets
// - Two-operator channel pairs slot n, n+3
// - Channel registers at offsets 0-8 per array
// - Six four-operator channels from 24 slots
// - Four-op parameters from offsets 0-2, second select bit from 3-5
// - Rhythm uses slots 13 to 18
// - Slots 31-36 only two-operator
// - Two-op select bit: serial or parallel
// - Key-on starts, key-off stops a note
// - Rhythm enable moves slots 13-18 to rhythm
module fmos_top #(
  parameter int P_EG_TICK_CYC = $rtoi(`FMOS_DECAY_R4_MS * `FMOS_NS_PER_MS /
    ((`FMOS_DB_RANGE / `FMOS_DB_STEP) * (2.0 ** `FMOS_RATE4_SHIFT)) / `FMOS_CLK_NS)
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire fmos_pkg::fmos_host_req_t i_host,
  output logic [7:0] o_host_rdata,
  output logic o_host_rvalid,
  output fmos_pkg::fmos_slot_out_t o_slot
);
  fmos_pkg::fmos_top_t q;
  fmos_pkg::fmos_top_t d;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_a;
  logic [7:0] mem_b;
  logic [7:0] rd_idx;
  logic [11:0] env_raw;
  fmos_pkg::fmos_env_t env_rd;
  fmos_pkg::fmos_env_t env_nx;
  logic [5:0] env_rate;
  logic env_we;
  logic arr_s;
  logic [7:0] off;
  logic [3:0] ch;
  logic [1:0] cmod;
  logic [2:0] cidx;
  logic four;
  logic [3:0] kc;
  logic rhy_slot;
  logic rhy_key;
  logic key;
  logic tick_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Register arrays and envelope state.

  fmos_regmem #(.AW(9), .DW(8), .DEPTH(512)) u_regs (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_we(mem_we),
    .i_waddr({q.arr, q.index}),
    .i_wdata(mem_wdata),
    .i_raddr_a({arr_s, rd_idx}),
    .o_rdata_a(mem_a),
    .i_raddr_b({q.arr, q.index}),
    .o_rdata_b(mem_b)
  );

  fmos_regmem #(.AW(6), .DW(12), .DEPTH(36),
    .P_RST({fmos_pkg::ENV_RELEASE, 1'b0, `FMOS_LVL_MAX})) u_env_mem (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_we(env_we),
    .i_waddr(q.slot),
    .i_wdata(env_nx),
    .i_raddr_a(q.slot),
    .o_rdata_a(env_raw),
    .i_raddr_b(6'h00),
    .o_rdata_b()
  );

  fmos_env_step u_env_step (
    .i_env(env_rd),
    .i_key(key),
    .i_sustain_type(q.r_egt[`FMOS_EGT_BIT]),
    .i_ksr(q.r_egt[`FMOS_KSR_BIT]),
    .i_ar(q.r_adr[7:4]),
    .i_dr(q.r_adr[3:0]),
    .i_sl(q.r_srr[7:4]),
    .i_rr(q.r_srr[3:0]),
    .i_ksn(q.r_key[4:1]),
    .i_eg_cnt(q.eg_cnt),
    .o_env(env_nx),
    .o_rate(env_rate)
  );

  // Channel registers reset to a non-zero value, so they are kept inverted in those bits
  // and the whole array can reset to zero.
  assign mem_wdata = i_host.wdata ^ fmos_pkg::fmos_chan_xor(q.index);
  assign env_rd = fmos_pkg::fmos_env_t'(env_raw);
  assign env_we = (q.seq == fmos_pkg::SEQ_WRITE);
  assign tick_hit = (q.tick == 11'(P_EG_TICK_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // Slot to channel mapping of the slot being visited.

  always_comb begin
    arr_s = (q.slot >= `FMOS_SLOTS_PER_ARRAY);
    off = fmos_pkg::fmos_slot_offset(q.slot);
    ch = fmos_pkg::fmos_slot_chan(q.slot);
    cmod = 2'(ch % `FMOS_QUAD_CH);
    cidx = {1'b0, cmod} + (arr_s ? 3'(`FMOS_QUAD_CH) : 3'h0);
    four = (ch < 4'(2 * `FMOS_QUAD_CH)) && q.conn[cidx];
    kc = four ? {2'b00, cmod} : ch;
    rhy_slot = q.rhythm[`FMOS_RHY_EN] && !arr_s && (ch >= 4'(2 * `FMOS_QUAD_CH));
    case (off[2:0])
      3'h0, 3'h3: rhy_key = q.rhythm[`FMOS_RHY_BD];
      3'h1: rhy_key = q.rhythm[`FMOS_RHY_HH];
      3'h2: rhy_key = q.rhythm[`FMOS_RHY_TOM];
      3'h4: rhy_key = q.rhythm[`FMOS_RHY_SD];
      default: rhy_key = q.rhythm[`FMOS_RHY_TC];
    endcase
    key = rhy_slot ? rhy_key : q.r_key[`FMOS_KEY_BIT];
    case (q.sub)
      3'h0: rd_idx = `FMOS_GRP_EGT + off;
      3'h1: rd_idx = `FMOS_GRP_ADR + off;
      3'h2: rd_idx = `FMOS_GRP_SRR + off;
      3'h3: rd_idx = `FMOS_GRP_WAVE + off;
      3'h4: rd_idx = `FMOS_GRP_KEY + {4'h0, kc};
      3'h5: rd_idx = `FMOS_GRP_CHAN + {4'h0, kc};
      default: rd_idx = `FMOS_GRP_CHAN + {4'h0, kc + `FMOS_QUAD_CH};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: host ports, sweep timer and slot sequencer.

  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    d.rd_pend = 1'b0;
    d.out.valid = 1'b0;
    mem_we = 1'b0;
    if (i_host.wr && !i_host.sel[0]) begin
      d.index = i_host.wdata;
      d.arr = i_host.sel[1];
    end
    if (i_host.wr && i_host.sel[0]) begin
      mem_we = !fmos_pkg::fmos_is_hole(q.index);
      if (!q.arr && q.index == `FMOS_IDX_RHYTHM) begin
        d.rhythm = i_host.wdata;
      end else if (q.arr && q.index == `FMOS_IDX_CONN) begin
        d.conn = i_host.wdata[5:0];
      end else if (q.arr && q.index == `FMOS_IDX_EXT) begin
        d.ext = i_host.wdata[0];
      end
    end
    if (i_host.rd) begin
      d.rd_pend = 1'b1;
      d.rd_dp = i_host.sel[0];
      d.rd_xor = fmos_pkg::fmos_chan_xor(q.index);
    end
    if (q.rd_pend) begin
      d.rvalid = 1'b1;
      d.rdata = q.rd_dp ? (mem_b ^ q.rd_xor) : 8'h00;
    end
    d.tick = tick_hit ? 11'h000 : q.tick + 11'h001;
    if (tick_hit) begin
      d.eg_cnt = q.eg_cnt + 16'h0001;
    end
    case (q.seq)
      fmos_pkg::SEQ_IDLE: begin
        if (tick_hit) begin
          d.seq = fmos_pkg::SEQ_READ;
          d.sub = 3'h0;
          d.slot = 6'h00;
        end
      end
      fmos_pkg::SEQ_READ: begin
        d.sub = q.sub + 3'h1;
        case (q.sub)
          3'h1: d.r_egt = mem_a;
          3'h2: d.r_adr = mem_a;
          3'h3: d.r_srr = mem_a;
          3'h4: d.r_wave = mem_a;
          3'h5: d.r_key = mem_a;
          3'h6: d.r_chan = mem_a ^ `FMOS_CHAN_RST;
          3'h7: begin
            d.r_chan3 = mem_a ^ `FMOS_CHAN_RST;
            d.seq = fmos_pkg::SEQ_WRITE;
          end
          default: ;
        endcase
      end
      default: begin
        d.out.valid = 1'b1;
        d.out.slot = q.slot;
        d.out.level = env_nx.level;
        d.out.wave = q.ext ? q.r_wave[2:0] : {1'b0, q.r_wave[1:0]};
        d.out.alg = four ? {q.r_chan[0], q.r_chan3[0]} : {1'b0, q.r_chan[0]};
        d.out.left = q.ext ? q.r_chan[4] : 1'b1;
        d.out.right = q.ext ? q.r_chan[5] : 1'b1;
        d.out.four_op = four;
        d.out.rhythm = rhy_slot;
        if (q.slot == `FMOS_SLOTS - 6'h01) begin
          d.seq = fmos_pkg::SEQ_IDLE;
        end else begin
          d.slot = q.slot + 6'h01;
          d.sub = 3'h0;
          d.seq = fmos_pkg::SEQ_READ;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_host_rdata = q.rdata;
  assign o_host_rvalid = q.rvalid;
  assign o_slot = q.out;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  chk_legacy_pan: assert property (o_slot.valid && !$past(q.ext) |->
    o_slot.left && o_slot.right) else $error("legacy mode must enable both outputs");
  chk_legacy_wave: assert property (o_slot.valid && !$past(q.ext) |->
    o_slot.wave == {1'b0, $past(q.r_wave[1:0])}) else $error("legacy waveform not limited");
  chk_wave_field: assert property (o_slot.valid && $past(q.ext) |->
    o_slot.wave == $past(q.r_wave[2:0])) else $error("waveform field not passed");
  chk_alg_select: assert property (o_slot.valid |-> o_slot.alg ==
    (o_slot.four_op ? {$past(q.r_chan[0]), $past(q.r_chan3[0])} : {1'b0, $past(q.r_chan[0])}))
    else $error("algorithm select wrong");
  // Holes are never stored, so whatever was written there must read back as zero.
  chk_hole_read: assert property (i_host.rd && i_host.sel[0] &&
    fmos_pkg::fmos_is_hole(q.index) |-> ##2 o_host_rdata == 8'h00)
    else $error("unmapped slot index read back non-zero");
  chk_rate_stall: assert property (env_we && env_rate < `FMOS_RATE_MIN &&
    env_nx.phase == env_rd.phase |-> env_nx.level == env_rd.level)
    else $error("frozen rate moved the level");
  chk_sustain_hold: assert property (env_we && env_rd.phase == fmos_pkg::ENV_SUSTAIN &&
    key && env_rd.key_prev && q.r_egt[`FMOS_EGT_BIT] |->
    env_nx.phase == fmos_pkg::ENV_SUSTAIN && env_nx.level == env_rd.level)
    else $error("sustain not held");
  chk_key_release: assert property (env_we && !key && env_rd.key_prev |->
    env_nx.phase == fmos_pkg::ENV_RELEASE) else $error("key off did not release");
  chk_rhythm_slots: assert property (o_slot.valid && o_slot.rhythm |->
    o_slot.slot >= 6'h0C && o_slot.slot <= 6'h11) else $error("rhythm on wrong slot");
  chk_four_slots: assert property (o_slot.valid && o_slot.four_op |->
    !(o_slot.slot inside {[6'h0C:6'h11], [6'h1E:6'h23]})) else $error("four-op on wrong slot");
  chk_host_read: assert property (i_host.rd |-> ##2 o_host_rvalid)
    else $error("read answer late");
  chk_read_answer: assert property (o_host_rvalid |-> $past(i_host.rd, 2))
    else $error("read answer without request");
  chk_index_read: assert property (i_host.rd && !i_host.sel[0] |-> ##2 o_host_rdata == 8'h00)
    else $error("index port read not zero");
  chk_pan_ext: assert property (o_slot.valid && $past(q.ext) |->
    o_slot.left == $past(q.r_chan[4]) && o_slot.right == $past(q.r_chan[5]))
    else $error("output enables not passed");
  // Each slot takes eight read cycles and one write cycle, so pulses come nine apart.
  chk_slot_order: assert property (o_slot.valid && o_slot.slot != `FMOS_SLOTS - 6'h01 |->
    ##9 (o_slot.valid && o_slot.slot == $past(o_slot.slot, 9) + 6'h01))
    else $error("slot sweep out of order");

  ////////////////////////////////////////////////////////////////////////////////
  // Envelope checks.

  chk_key_attack: assert property (env_we && key && !env_rd.key_prev |->
    env_nx.phase == fmos_pkg::ENV_ATTACK || env_nx.phase == fmos_pkg::ENV_DECAY)
    else $error("key on did not start a note");
  chk_fast_attack: assert property (env_we && key && !env_rd.key_prev &&
    env_rate >= `FMOS_RATE_FAST |-> env_nx.level == 9'h000)
    else $error("fastest attack did not reach full level");
  chk_attack_rise: assert property (env_we && env_rd.phase == fmos_pkg::ENV_ATTACK &&
    env_nx.phase == fmos_pkg::ENV_ATTACK |-> env_nx.level <= env_rd.level)
    else $error("attack made the level quieter");
  // Release only ever adds one step of attenuation per visit, never jumps.
  chk_release_step: assert property (env_we && env_rd.phase == fmos_pkg::ENV_RELEASE &&
    env_nx.phase == fmos_pkg::ENV_RELEASE |->
    env_nx.level == env_rd.level || env_nx.level == env_rd.level + 9'h001)
    else $error("release step not linear");
  cov_rhythm: cover property (o_slot.valid && o_slot.rhythm);
  cov_four_op: cover property (o_slot.valid && o_slot.four_op);
  cov_release: cover property (env_we && env_nx.phase == fmos_pkg::ENV_RELEASE);
  cov_host_read: cover property (i_host.rd && i_host.sel[0]);
  cov_sustain: cover property (env_we && env_nx.phase == fmos_pkg::ENV_SUSTAIN);
endmodule : fmos_top

// *** hw/fmos_defs.svh ***
// Offsets, field positions, reset values and timing figures of the operator-slot block.
`ifndef FMOS_DEFS_SVH
`define FMOS_DEFS_SVH
`define FMOS_SLOTS 6'h24
`define FMOS_SLOTS_PER_ARRAY 6'h12
`define FMOS_GRP_SLOTS 5'h06
`define FMOS_GRP_STRIDE 5'h08
`define FMOS_QUAD_CH 4'h3
`define FMOS_GRP_EGT 8'h20
`define FMOS_GRP_ADR 8'h60
`define FMOS_GRP_SRR 8'h80
`define FMOS_GRP_KEY 8'hB0
`define FMOS_GRP_CHAN 8'hC0
`define FMOS_GRP_CHAN_LAST 8'hC8
`define FMOS_GRP_WAVE 8'hE0
`define FMOS_IDX_RHYTHM 8'hBD
`define FMOS_IDX_CONN 8'h04
`define FMOS_IDX_EXT 8'h05
`define FMOS_CHAN_RST 8'h30
`define FMOS_RHY_EN 5
`define FMOS_RHY_BD 4
`define FMOS_RHY_SD 3
`define FMOS_RHY_TOM 2
`define FMOS_RHY_TC 1
`define FMOS_RHY_HH 0
`define FMOS_KEY_BIT 5
`define FMOS_EGT_BIT 5
`define FMOS_KSR_BIT 4
`define FMOS_LVL_MAX 9'h1FF
`define FMOS_SL_MAX_LVL 9'h1F0
`define FMOS_RATE_MIN 6'h04
`define FMOS_RATE_FAST 6'h3C
`define FMOS_RATE_TOP 6'h3F
`define FMOS_SHIFT_TOP 4'hF
`define FMOS_DB_RANGE 96.0
`define FMOS_DB_STEP 0.1875
`define FMOS_DECAY_R4_MS 39280.64
`define FMOS_RATE4_SHIFT 14
`define FMOS_NS_PER_MS 1.0e6
`define FMOS_CLK_NS 4.0
`endif

// *** hw/fmos_pkg.sv ***
// Types and slot-mapping functions of the operator-slot block.
`include "fmos_defs.svh"
package fmos_pkg;
  typedef enum logic [1:0] {ENV_ATTACK, ENV_DECAY, ENV_SUSTAIN, ENV_RELEASE} fmos_phase_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_READ, SEQ_WRITE} fmos_seq_t;
  typedef struct packed {
    fmos_phase_t phase;
    logic key_prev;
    logic [8:0] level;
  } fmos_env_t;
  typedef struct packed {
    logic [1:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } fmos_host_req_t;
  typedef struct packed {
    logic valid;
    logic [5:0] slot;
    logic [8:0] level;
    logic [2:0] wave;
    logic [1:0] alg;
    logic left;
    logic right;
    logic four_op;
    logic rhythm;
  } fmos_slot_out_t;
  typedef struct packed {
    logic [7:0] index;
    logic arr;
    logic rd_pend;
    logic rd_dp;
    logic [7:0] rd_xor;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] rhythm;
    logic [5:0] conn;
    logic ext;
    fmos_seq_t seq;
    logic [2:0] sub;
    logic [5:0] slot;
    logic [10:0] tick;
    logic [15:0] eg_cnt;
    logic [7:0] r_egt;
    logic [7:0] r_adr;
    logic [7:0] r_srr;
    logic [7:0] r_wave;
    logic [7:0] r_key;
    logic [7:0] r_chan;
    logic [7:0] r_chan3;
    fmos_slot_out_t out;
  } fmos_top_t;

  function automatic logic [4:0] fmos_slot_local(input logic [5:0] s);
    return (s >= `FMOS_SLOTS_PER_ARRAY) ? 5'(s - `FMOS_SLOTS_PER_ARRAY) : s[4:0];
  endfunction : fmos_slot_local

  function automatic logic [7:0] fmos_slot_offset(input logic [5:0] s);
    logic [4:0] l;
    l = fmos_slot_local(s);
    return {3'h0, 5'((l / `FMOS_GRP_SLOTS) * `FMOS_GRP_STRIDE + l % `FMOS_GRP_SLOTS)};
  endfunction : fmos_slot_offset

  function automatic logic [3:0] fmos_slot_chan(input logic [5:0] s);
    logic [4:0] l;
    l = fmos_slot_local(s);
    return 4'((l / `FMOS_GRP_SLOTS) * 5'(`FMOS_QUAD_CH) + (l % `FMOS_GRP_SLOTS) % 5'(`FMOS_QUAD_CH));
  endfunction : fmos_slot_chan

  function automatic logic fmos_is_hole(input logic [7:0] idx);
    return idx[2] && idx[1] && (idx[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                                4'h8, 4'h9, 4'hE, 4'hF});
  endfunction : fmos_is_hole

  function automatic logic [7:0] fmos_chan_xor(input logic [7:0] idx);
    return (idx >= `FMOS_GRP_CHAN && idx <= `FMOS_GRP_CHAN_LAST) ? `FMOS_CHAN_RST : 8'h00;
  endfunction : fmos_chan_xor
endpackage : fmos_pkg

// *** hw/fmos_regmem.sv ***
// Small resettable memory with one write port and two registered read ports.
module fmos_regmem #(
  parameter int AW = 9,
  parameter int DW = 8,
  parameter int DEPTH = 512,
  parameter logic [DW-1:0] P_RST = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  output logic [DW-1:0] o_rdata_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [DW-1:0] o_rdata_b
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= P_RST;
      end
      o_rdata_a <= P_RST;
      o_rdata_b <= P_RST;
    end else begin
      if (i_we) begin
        mem_q[i_waddr] <= i_wdata;
      end
      o_rdata_a <= mem_q[i_raddr_a];
      o_rdata_b <= mem_q[i_raddr_b];
    end
  end
endmodule : fmos_regmem

// *** hw/fmos_env_step.sv ***
// One envelope update of one slot: rate scaling, phase change and level step.
`include "fmos_defs.svh"
module fmos_env_step (
  input wire fmos_pkg::fmos_env_t i_env,
  input wire logic i_key,
  input wire logic i_sustain_type,
  input wire logic i_ksr,
  input wire logic [3:0] i_ar,
  input wire logic [3:0] i_dr,
  input wire logic [3:0] i_sl,
  input wire logic [3:0] i_rr,
  input wire logic [3:0] i_ksn,
  input wire logic [15:0] i_eg_cnt,
  output fmos_pkg::fmos_env_t o_env,
  output logic [5:0] o_rate
);
  function automatic logic [5:0] eff_rate(input logic [3:0] v, input logic ksr,
                                          input logic [3:0] ksn);
    logic [6:0] r;
    r = {1'b0, v, 2'b00} + {3'h0, (ksr ? ksn : {2'b00, ksn[3:2]})};
    return (v == 4'h0) ? 6'h00 : ((r > 7'(`FMOS_RATE_TOP)) ? `FMOS_RATE_TOP : r[5:0]);
  endfunction : eff_rate

  // Each rate group of four halves the step period; the low two rate bits are not used.
  function automatic logic due(input logic [5:0] rate, input logic [15:0] cnt);
    logic [15:0] mask;
    mask = (16'h0001 << (`FMOS_SHIFT_TOP - rate[5:2])) - 16'h0001;
    return (rate >= `FMOS_RATE_MIN) && ((cnt & mask) == 16'h0000);
  endfunction : due

  logic [5:0] ar_r;
  logic [5:0] dr_r;
  logic [5:0] rr_r;
  logic [8:0] sl_lvl;

  always_comb begin
    ar_r = eff_rate(i_ar, i_ksr, i_ksn);
    dr_r = eff_rate(i_dr, i_ksr, i_ksn);
    rr_r = eff_rate(i_rr, i_ksr, i_ksn);
    sl_lvl = (i_sl == 4'hF) ? `FMOS_SL_MAX_LVL : {1'b0, i_sl, 4'h0};
    o_env = i_env;
    o_env.key_prev = i_key;
    o_rate = 6'h00;
    if (i_key && !i_env.key_prev) begin
      o_env.phase = fmos_pkg::ENV_ATTACK;
      o_rate = ar_r;
      if (ar_r >= `FMOS_RATE_FAST) begin
        o_env.level = 9'h000;
        o_env.phase = fmos_pkg::ENV_DECAY;
      end
    end else if (!i_key && i_env.key_prev) begin
      o_env.phase = fmos_pkg::ENV_RELEASE;
    end else begin
      case (i_env.phase)
        fmos_pkg::ENV_ATTACK: begin
          o_rate = ar_r;
          if (i_env.level == 9'h000) begin
            o_env.phase = fmos_pkg::ENV_DECAY;
          end else if (ar_r >= `FMOS_RATE_FAST) begin
            o_env.level = 9'h000;
          end else if (due(ar_r, i_eg_cnt)) begin
            o_env.level = i_env.level - ((i_env.level >> 3) + 9'h001);
          end
        end
        fmos_pkg::ENV_DECAY: begin
          o_rate = dr_r;
          if (i_env.level >= sl_lvl) begin
            o_env.phase = i_sustain_type ? fmos_pkg::ENV_SUSTAIN : fmos_pkg::ENV_RELEASE;
          end else if (due(dr_r, i_eg_cnt)) begin
            o_env.level = i_env.level + 9'h001;
          end
        end
        fmos_pkg::ENV_SUSTAIN: begin
          if (!i_sustain_type) begin
            o_env.phase = fmos_pkg::ENV_RELEASE;
          end
        end
        default: begin
          o_rate = rr_r;
          if (due(rr_r, i_eg_cnt) && i_env.level != `FMOS_LVL_MAX) begin
            o_env.level = i_env.level + 9'h001;
          end
        end
      endcase
    end
  end
endmodule : fmos_env_step

// *** test/fmos_host_model.sv ***
// Host model that drives index and data accesses on the register port.
module fmos_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output fmos_pkg::fmos_host_req_t o_host
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_host = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A released port carries the inverse select and data of the last request with both strobes low, so stale values never match.
  task automatic drive(input logic [1:0] sel, input logic wr, input logic rd, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_host = '{sel, wr, rd, d};
    @(negedge i_sys_clk);
    o_host = '{~sel, 1'b0, 1'b0, ~d};
  endtask : drive

  // Slot roles in serial channels are the caller's choice; the model writes what it is told.
  task automatic write_reg(input logic arr, input logic [7:0] idx, input logic [7:0] d);
    drive({arr, 1'b0}, 1'b1, 1'b0, idx);
    drive({arr, 1'b1}, 1'b1, 1'b0, d);
  endtask : write_reg

  // The request was taken one edge before drive returns; lat names the edge, counted from
  // that one, whose cycle carries the answer, and the data is read while that answer stands.
  task automatic read_port(input logic [1:0] sel, output logic [7:0] d, output int lat);
    drive(sel, 1'b0, 1'b1, 8'h00);
    lat = 1;
    while (i_rvalid !== 1'b1 && lat < 8) begin
      @(negedge i_sys_clk);
      lat++;
    end
    d = i_rdata;
  endtask : read_port
endmodule : fmos_host_model

// *** test/fmos_top_tb.sv ***
// Self-checking bench of the operator-slot block: registers, slot stream and envelopes.
module fmos_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 400;
  logic i_sys_clk;
  logic i_resetn;
  fmos_pkg::fmos_host_req_t host;
  logic [7:0] rdata;
  logic rvalid;
  fmos_pkg::fmos_slot_out_t so;
  fmos_pkg::fmos_slot_out_t seen;
  logic [7:0] rv;
  logic [7:0] holes [4] = '{8'h26, 8'h2F, 8'hE7, 8'hFE};
  int lat;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  fmos_top #(.P_EG_TICK_CYC(TICK)) fmos_top_i (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_host(host),
    .o_host_rdata(rdata), .o_host_rvalid(rvalid), .o_slot(so));

  fmos_host_model fmos_host_model_i (
    .i_sys_clk(i_sys_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_host(host));

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // The ceiling is several times the longest expected run of the sequence below.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("BAD run length expected below 40000 seen %0d", cycles);
      wrap_up();
    end
  end

  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  task automatic cmp_slot(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_slot

  task automatic wr(input logic arr, input logic [7:0] idx, input logic [7:0] d);
    fmos_host_model_i.write_reg(arr, idx, d);
  endtask : wr

  // Read answers must arrive exactly two edges after the request is taken.
  task automatic chk(input string what, input logic arr, input logic [7:0] idx,
                     input logic [7:0] exp);
    fmos_host_model_i.drive({arr, 1'b0}, 1'b1, 1'b0, idx);
    fmos_host_model_i.read_port({arr, 1'b1}, rv, lat);
    cmp_byte(what, exp, rv);
    cmp_byte("read latency", 8'h02, 8'(lat));
  endtask : chk

  // Waits for k pulses of slot s; a pulse already in flight may carry older settings.
  task automatic grab(input logic [5:0] s, input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(negedge i_sys_clk);
        n++;
      end while (!(so.valid === 1'b1 && so.slot === s) && n < 2 * TICK);
      cmp_byte("slot pulse", 8'h01, 8'(n < 2 * TICK));
      seen = so;
    end
  endtask : grab

  // Packs wave, select bits, left, right, four-op and rhythm flags for one compare.
  function automatic logic [8:0] attrs(input fmos_pkg::fmos_slot_out_t x);
    return {x.wave, x.alg, x.left, x.right, x.four_op, x.rhythm};
  endfunction : attrs

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_resetn = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'b1;
    chk("wave reset", 1'b0, 8'hE0, 8'h00);
    chk("chan reset", 1'b1, 8'hC8, 8'h30);
    fmos_host_model_i.read_port(2'b00, rv, lat);
    cmp_byte("index port read", 8'h00, rv);
    wr(1'b0, 8'hC0, 8'hFF);
    chk("chan unused bits", 1'b0, 8'hC0, 8'hFF);
    foreach (holes[i]) begin
      wr(1'b0, holes[i], 8'h5A);
      chk("hole", 1'b0, holes[i], 8'h00);
    end
    wr(1'b0, 8'hE0, 8'h07);
    wr(1'b1, 8'hE0, 8'h05);
    chk("wave array0", 1'b0, 8'hE0, 8'h07);
    chk("wave array1", 1'b1, 8'hE0, 8'h05);
    chk("wave slot36", 1'b1, 8'hF5, 8'h00);
    $display("test registers done");
    wr(1'b0, 8'hC0, 8'h10);
    grab(6'h00, 2);
    cmp_slot("legacy attrs", 9'h0CC, attrs(seen));
    cmp_slot("reset level", 9'h1FF, seen.level);
    wr(1'b1, 8'h05, 8'h01);
    grab(6'h00, 2);
    cmp_slot("extended attrs", 9'h1C8, attrs(seen));
    wr(1'b0, 8'hC0, 8'h21);
    grab(6'h03, 2);
    cmp_slot("pair slot attrs", 9'h014, attrs(seen));
    $display("test legacy and two-op done");
    wr(1'b1, 8'h04, 8'h01);
    wr(1'b0, 8'hC3, 8'h01);
    grab(6'h06, 2);
    cmp_slot("four-op alg 3", 9'h036, attrs(seen));
    wr(1'b0, 8'hC3, 8'h00);
    grab(6'h09, 2);
    cmp_slot("four-op alg 2", 9'h026, attrs(seen));
    wr(1'b1, 8'h04, 8'h3F);
    grab(6'h12, 2);
    cmp_slot("four-op array1", 9'h14E, attrs(seen));
    grab(6'h1E, 1);
    cmp_slot("two-op only slot", 9'h00C, attrs(seen));
    wr(1'b0, 8'hBD, 8'h20);
    grab(6'h0B, 2);
    cmp_slot("melodic slot", 9'h00E, attrs(seen));
    grab(6'h0C, 1);
    cmp_slot("rhythm slot", 9'h00D, attrs(seen));
    wr(1'b0, 8'hBD, 8'h00);
    wr(1'b1, 8'h04, 8'h00);
    $display("test four-op and rhythm done");
    wr(1'b0, 8'h20, 8'h20);
    wr(1'b0, 8'h60, 8'hFF);
    wr(1'b0, 8'h80, 8'h0F);
    wr(1'b0, 8'h61, 8'hFF);
    wr(1'b0, 8'h81, 8'h0F);
    wr(1'b0, 8'hB0, 8'h20);
    wr(1'b0, 8'hB1, 8'h20);
    wr(1'b0, 8'hB2, 8'h20);
    grab(6'h00, 3);
    cmp_slot("attack level", 9'h000, seen.level);
    grab(6'h02, 1);
    cmp_slot("rate zero level", 9'h1FF, seen.level);
    grab(6'h00, 3);
    cmp_slot("sustain level", 9'h000, seen.level);
    grab(6'h01, 1);
    cmp_slot("percussive moved", 9'h001, 9'(seen.level !== 9'h000));
    wr(1'b0, 8'hB0, 8'h00);
    grab(6'h00, 3);
    cmp_slot("release moved", 9'h001, 9'(seen.level !== 9'h000));
    $display("test envelope done");
    wrap_up();
  end
endmodule : fmos_top_tb
